/* File: rtl/timer_pwm_regs.svh */
// Register map, field positions, reset values and rate figures of the timer and trio PWM.
// Assumes a word-addressed Avalon-MM slave: the address port carries the register index.
`ifndef TIMER_PWM_REGS_SVH
`define TIMER_PWM_REGS_SVH

// Register indices; byte address is four times the index
`define TP_IDX_FREEZE_SET   32'h5000_3300
`define TP_IDX_FREEZE_CLR   32'h5000_3302
`define TP_IDX_TIMER_CTRL   32'h5000_3400
`define TP_IDX_ON_RELOAD    32'h5000_3402
`define TP_IDX_HIGH_RELOAD  32'h5000_3404
`define TP_IDX_LOW_RELOAD   32'h5000_3406
`define TP_IDX_DUTY_A       32'h5000_3408
`define TP_IDX_DUTY_B       32'h5000_340A
`define TP_IDX_DUTY_C       32'h5000_340C
`define TP_IDX_PERIOD       32'h5000_340E
`define TP_IDX_TRIO_CTRL    32'h5000_3410
`define TP_IDX_FAST_SEL     32'h5000_3412

// Timer control fields
`define TP_BIT_RUN          0
`define TP_BIT_SRC_SEL      1
`define TP_BIT_BYPASS       2
`define TP_BIT_STYLE        3
// Trio control fields
`define TP_BIT_TRIO_EN      0
`define TP_BIT_SW_HOLD      1
`define TP_BIT_HW_ALLOW     2
// Freeze set and clear registers share this position
`define TP_BIT_FREEZE       1

// Reset values
`define TP_RST_TIMER_CTRL   4'h0
`define TP_RST_TRIO_CTRL    3'h4
`define TP_RST_FAST_SEL     2'h0

// Rates
`define TP_CLK_PERIOD_NS    4
`define TP_REF_HZ           250000000
`define TP_SLOW_HZ          32000
`define TP_FAST_HZ          16000000
`define TP_PRESCALE         10

`endif

/* File: rtl/timer_pwm_pkg.sv */
// Types shared by the timer and the trio PWM unit.
// Assumes nothing beyond a SystemVerilog compiler.
package timer_pwm_pkg;

	// Timer phase, high or low
	typedef enum logic {PH_HIGH, PH_LOW} phase_e;

	// One trio duty or period value
	typedef logic [13:0] trio_val_t;

	// Duty values of the three channels
	typedef trio_val_t [2:0] trio_duty_t;

endpackage

/* File: rtl/trio_if.sv */
// Carrier between the register file and the trio PWM unit.
// Assumes both ends run on ref_clk.
`timescale 1ns/100ps
interface trio_if;
	timer_pwm_pkg::trio_val_t  period;   // Shared period
	timer_pwm_pkg::trio_duty_t duty;     // Per-channel duty
	logic                      enable;   // Unit enabled
	logic                      hold;     // Pause request, software or hardware
	logic [2:0]                outs;     // Channel outputs

	modport ctrl (output period, output duty, output enable, output hold, input outs);
	modport unit (input period, input duty, input enable, input hold, output outs);
endinterface

/* File: rtl/rate_nco.sv */
// Fractional rate generator: a one-cycle tick at an average rate set by inc.
// Assumes inc = rate * 2^32 / ref_clk rate, held steady.
`timescale 1ns/100ps
module rate_nco
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [31:0] inc,
	output logic             tick
);
	logic [32:0] next_acc;  // Sum with carry out
	logic [31:0] acc;       // Phase accumulator

	assign next_acc = {1'b0, acc} + {1'b0, inc};

	// Carry of the accumulator is the tick; jitter is one ref_clk cycle at most
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			acc  <= 32'h0000_0000;
			tick <= 1'b0;
		end
		else
		begin
			acc  <= next_acc[31:0];
			tick <= next_acc[32];
		end
	end
endmodule

/* File: rtl/trio_pwm.sv */
// Three PWM channels sharing one period counter.
// Assumes period, duty and control come steady from the register file.
`timescale 1ns/100ps
module trio_pwm
(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	trio_if.unit      bus
);
	timer_pwm_pkg::trio_val_t cnt;       // Shared position in the period
	logic                     wrap;      // Last count of the period

	assign wrap = (cnt >= bus.period - 14'h0001) || (bus.period == 14'h0000);

	// Shared counter; frozen while paused, cleared while disabled
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt <= 14'h0000;
		else if (!bus.enable)
			cnt <= 14'h0000;                        // [R12]
		else if (!bus.hold)                          // [R13] [R14]
			cnt <= wrap ? 14'h0000 : cnt + 14'h0001; // [R11] [R16]
	end

	// One comparator per channel; outputs hold their level during a pause
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++)
		begin : g_ch
			always_ff @(posedge ref_clk or posedge sys_rst)
			begin
				if (sys_rst)
					bus.outs[ch] <= 1'b0;
				else if (!bus.enable)
					bus.outs[ch] <= 1'b0;                    // [R12]
				else if (!bus.hold)
					bus.outs[ch] <= cnt < bus.duty[ch];      // [R10] [R16]
			end
		end
	endgenerate
endmodule

/* File: rtl/timer_pwm_top.sv */
// Timer with two PWM outputs and a three-channel PWM unit behind an Avalon-MM slave.
// Assumes a word-addressed master; the slow and fast time bases are made here from ref_clk.
//
// Operation
// R1: Style zero drives constant one during high
// R2: Style one sends fast clock halved during high
// R3: Bypass one uses clock; zero divides by ten
// R4: Prescaler affects only the on counter
// R5: Source one picks fast clock; zero 32 kHz
// R6: Run zero holds timer reset; one runs
// R7: On reload writes store; reads give on_counter
// R8: High reload writes store; reads give phase_counter
// R9: Low reload writes store; reads give phase_counter
// R10: Each trio channel has its own duty
// R11: Trio channels share one period value
// R12: Trio runs only when enabled; resets off
// R13: Software hold pauses all trio channels
// R14: Hardware hold allowed by bit, resets set
// R15: Freeze set stops timer; writing zero ignored
// R16: Channel high while count below its duty
// R17: Timer alternates high and low reload phases
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "timer_pwm_regs.svh"
module timer_pwm_top
#(
	parameter int SLOW_HZ = `TP_SLOW_HZ   // Slow time base rate
)
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [31:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        hw_hold_req,
	output logic             timer_pwm_high,
	output logic             timer_pwm_low,
	output logic [2:0]       trio_pwm_out
);
	// Rate increments, 2^32 * rate / ref rate
	localparam logic [63:0] SLOW_INC64 = (64'd1 << 32) * 64'(SLOW_HZ) / 64'(`TP_REF_HZ);
	localparam logic [63:0] FAST_INC64 = (64'd1 << 32) * 64'(`TP_FAST_HZ) / 64'(`TP_REF_HZ);
	localparam logic [31:0] SLOW_INC   = SLOW_INC64[31:0];
	localparam logic [31:0] FAST_INC   = FAST_INC64[31:0];

	// Software registers
	logic [3:0]  timer_ctrl;    // Style, bypass, source, run
	logic [15:0] on_reload;     // On counter reload
	logic [15:0] high_reload;   // High phase reload
	logic [15:0] low_reload;    // Low phase reload
	logic [2:0]  trio_ctrl;     // Hw allow, sw hold, enable
	logic [1:0]  fast_sel;      // Fast rate: 16, 8, 4, 2 MHz
	logic        sw_timer_freeze; // Timer frozen
	timer_pwm_pkg::trio_val_t  period_value;
	timer_pwm_pkg::trio_duty_t duty_value;

	// Timer state
	logic [15:0] on_counter;    // Live on counter
	logic [15:0] phase_counter; // Live phase counter
	logic [3:0]  pre_cnt;       // Divide-by-ten prescaler
	logic [2:0]  fast_div;      // Fast rate divider
	logic        fast_half;     // Fast clock halved
	timer_pwm_pkg::phase_e phase;

	// Bus handshake
	logic        ack;           // Second cycle of an access
	logic        req;           // Access pending

	// Control fields
	wire timer_run                = timer_ctrl[`TP_BIT_RUN];
	wire timebase_source_sel      = timer_ctrl[`TP_BIT_SRC_SEL];
	wire on_count_prescale_bypass = timer_ctrl[`TP_BIT_BYPASS];
	wire output_style_sel         = timer_ctrl[`TP_BIT_STYLE];
	wire trio_output_enable       = trio_ctrl[`TP_BIT_TRIO_EN];
	wire sw_hold                  = trio_ctrl[`TP_BIT_SW_HOLD];
	wire hw_hold_allow            = trio_ctrl[`TP_BIT_HW_ALLOW];

	// Address decode
	wire sel_fz_set = address == `TP_IDX_FREEZE_SET;
	wire sel_fz_clr = address == `TP_IDX_FREEZE_CLR;
	wire sel_ctrl   = address == `TP_IDX_TIMER_CTRL;
	wire sel_on     = address == `TP_IDX_ON_RELOAD;
	wire sel_high   = address == `TP_IDX_HIGH_RELOAD;
	wire sel_low    = address == `TP_IDX_LOW_RELOAD;
	wire sel_da     = address == `TP_IDX_DUTY_A;
	wire sel_db     = address == `TP_IDX_DUTY_B;
	wire sel_dc     = address == `TP_IDX_DUTY_C;
	wire sel_per    = address == `TP_IDX_PERIOD;
	wire sel_trio   = address == `TP_IDX_TRIO_CTRL;
	wire sel_fast   = address == `TP_IDX_FAST_SEL;

	// Writes land on the acknowledging edge; only low byte lanes carry data
	wire wr_go = write && ack;
	wire be_lo = byteenable[0];
	wire be_hi = byteenable[1];

	// Time bases
	logic slow_tick;
	logic fast_base;
	wire  fast_tick = fast_base && (fast_div == 3'h0);
	wire  t_tick    = timebase_source_sel ? fast_tick : slow_tick;            // [R5]
	wire  on_tick   = on_count_prescale_bypass ? t_tick
	                  : (t_tick && pre_cnt == 4'(`TP_PRESCALE - 1));          // [R3] [R4]
	wire  advance   = timer_run && !sw_timer_freeze;                          // [R15]

	// Read selection; reload registers read back live counters
	logic [15:0] rd_mux;
	assign rd_mux =
		sel_fz_set ? {14'h0000, sw_timer_freeze, 1'b0} :
		sel_fz_clr ? {14'h0000, sw_timer_freeze, 1'b0} :
		sel_ctrl   ? {12'h000, timer_ctrl} :
		sel_on     ? on_counter :                                             // [R7]
		sel_high   ? phase_counter :                                          // [R8]
		sel_low    ? phase_counter :                                          // [R9]
		sel_da     ? {2'b00, duty_value[0]} :
		sel_db     ? {2'b00, duty_value[1]} :
		sel_dc     ? {2'b00, duty_value[2]} :
		sel_per    ? {2'b00, period_value} :
		sel_trio   ? {13'h0000, trio_ctrl} :
		sel_fast   ? {14'h0000, fast_sel} : 16'h0000;

	// One wait state on every access so read data come from a flip-flop
	assign req         = read || write;
	assign waitrequest = req && !ack;

	trio_if trio ();
	assign trio.period  = period_value;
	assign trio.duty    = duty_value;
	assign trio.enable  = trio_output_enable;                                 // [R12]
	assign trio.hold    = sw_hold || (hw_hold_allow && hw_hold_req);          // [R13] [R14]
	assign trio_pwm_out = trio.outs;

	rate_nco u_slow
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.inc     (SLOW_INC),
		.tick    (slow_tick)
	);

	rate_nco u_fast
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.inc     (FAST_INC),
		.tick    (fast_base)
	);

	trio_pwm u_trio
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.bus     (trio.unit)
	);

	// Handshake and read data
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack      <= 1'b0;
			readdata <= 32'h0000_0000;
		end
		else
		begin
			ack      <= req && !ack;
			readdata <= {16'h0000, rd_mux};
		end
	end

	// Timer control and reloads
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_ctrl  <= `TP_RST_TIMER_CTRL;
			on_reload   <= 16'h0000;
			high_reload <= 16'h0000;
			low_reload  <= 16'h0000;
			fast_sel    <= `TP_RST_FAST_SEL;
		end
		else
		begin
			// Low lane carries control and reload low bytes
			if (wr_go && be_lo)
			begin
				if (sel_ctrl)
					timer_ctrl <= writedata[3:0];
				if (sel_fast)
					fast_sel <= writedata[1:0];
				if (sel_on)
					on_reload[7:0] <= writedata[7:0];                         // [R7]
				if (sel_high)
					high_reload[7:0] <= writedata[7:0];                       // [R8]
				if (sel_low)
					low_reload[7:0] <= writedata[7:0];                        // [R9]
			end
			// High lane carries only the reload high bytes
			if (wr_go && be_hi)
			begin
				if (sel_on)
					on_reload[15:8] <= writedata[15:8];
				if (sel_high)
					high_reload[15:8] <= writedata[15:8];
				if (sel_low)
					low_reload[15:8] <= writedata[15:8];
			end
		end
	end

	// Trio settings; duty and period are written whole on the low lane alone
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trio_ctrl    <= `TP_RST_TRIO_CTRL;                                // [R12] [R14]
			period_value <= 14'h0000;
			duty_value   <= '0;
		end
		else if (wr_go && be_lo)
		begin
			if (sel_trio)
				trio_ctrl <= writedata[2:0];
			if (sel_per)
				period_value <= writedata[13:0];                              // [R11]
			if (sel_da)
				duty_value[0] <= writedata[13:0];                             // [R10]
			if (sel_db)
				duty_value[1] <= writedata[13:0];
			if (sel_dc)
				duty_value[2] <= writedata[13:0];
		end
	end

	// Freeze: a one in the set register freezes, in the clear register releases, zeros ignored
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			sw_timer_freeze <= 1'b0;
		else if (wr_go && be_lo && sel_fz_set && writedata[`TP_BIT_FREEZE])
			sw_timer_freeze <= 1'b1;                                          // [R15]
		else if (wr_go && be_lo && sel_fz_clr && writedata[`TP_BIT_FREEZE])
			sw_timer_freeze <= 1'b0;
	end

	// Fast rate divider and halved fast clock; the halved clock stops while frozen
	// so that a frozen timer in toggling style keeps its output level
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fast_div  <= 3'h0;
			fast_half <= 1'b0;
		end
		else
		begin
			if (fast_base)
				fast_div <= (fast_div >= ((3'h1 << fast_sel) - 3'h1)) ? 3'h0 : fast_div + 3'h1;
			if (fast_tick && !sw_timer_freeze)                                // [R15]
				fast_half <= !fast_half;                                      // [R2]
		end
	end

	// Prescaler and on counter; both sit in reset while the timer is off
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pre_cnt    <= 4'h0;
			on_counter <= 16'h0000;
		end
		else if (!timer_run)
		begin
			pre_cnt    <= 4'h0;                                               // [R6]
			on_counter <= 16'h0000;
		end
		else if (advance && t_tick)
		begin
			pre_cnt <= (pre_cnt == 4'(`TP_PRESCALE - 1)) ? 4'h0 : pre_cnt + 4'h1; // [R3]
			if (on_tick)
				on_counter <= (on_counter == 16'h0000) ? on_reload : on_counter - 16'h0001;
		end
	end

	// Phase counter at the undivided rate; expiry swaps phase and reloads
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase_counter <= 16'h0000;
			phase         <= timer_pwm_pkg::PH_LOW;
		end
		else if (!timer_run)
		begin
			phase_counter <= 16'h0000;                                        // [R6]
			phase         <= timer_pwm_pkg::PH_LOW;
		end
		else if (advance && t_tick)                                           // [R4] [R15]
		begin
			if (phase_counter != 16'h0000)
				phase_counter <= phase_counter - 16'h0001;
			else if (phase == timer_pwm_pkg::PH_LOW)
			begin
				phase         <= timer_pwm_pkg::PH_HIGH;                      // [R17]
				phase_counter <= high_reload;
			end
			else
			begin
				phase         <= timer_pwm_pkg::PH_LOW;                       // [R17]
				phase_counter <= low_reload;
			end
		end
	end

	// Output levels; a frozen timer keeps its level
	wire high_level = output_style_sel ? fast_half : 1'b1;                    // [R1] [R2]
	wire in_high    = timer_run && phase == timer_pwm_pkg::PH_HIGH;
	wire in_low     = timer_run && phase == timer_pwm_pkg::PH_LOW;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_pwm_high <= 1'b0;
			timer_pwm_low  <= 1'b0;
		end
		else
		begin
			timer_pwm_high <= in_high && high_level;                          // [R1]
			timer_pwm_low  <= in_low && high_level;
		end
	end
endmodule

/* File: testbench/timer_pwm_top_asserts.sv */
// Checker for the timer and trio PWM top; it sees only the top's ports.
// Assumes one clock domain and shadows control bits from completed bus writes.
`timescale 1ns/100ps
`include "timer_pwm_regs.svh"
module timer_pwm_top_asserts
(
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic [31:0] address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        hw_hold_req,
	input wire logic        timer_pwm_high,
	input wire logic        timer_pwm_low,
	input wire logic [2:0]  trio_pwm_out
);
	logic       wr_done;   // Write completes at this edge with the low lane
	logic [2:0] trio;      // Shadow of trio control
	logic [3:0] tctl;      // Shadow of timer control
	logic       frz;       // Shadow of the freeze state
	logic       hold;      // Pause seen by the trio unit

	assign wr_done = write && !waitrequest && byteenable[0];
	assign hold    = trio[1] | (trio[2] & hw_hold_req);

	// Follow control writes as the register file takes them
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trio <= `TP_RST_TRIO_CTRL;
			tctl <= `TP_RST_TIMER_CTRL;
			frz  <= 1'b0;
		end
		else if (wr_done)
		begin
			if (address == `TP_IDX_TRIO_CTRL)
				trio <= writedata[2:0];
			if (address == `TP_IDX_TIMER_CTRL)
				tctl <= writedata[3:0];
			if (address == `TP_IDX_FREEZE_SET && writedata[1])
				frz <= 1'b1;
			if (address == `TP_IDX_FREEZE_CLR && writedata[1])
				frz <= 1'b0;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	wait_one_a:
	assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("Access did not take exactly one wait state");
	upper_zero_a:
	assert property (readdata[31:16] == 16'h0000) else $error("Upper read half not zero");
	unmapped_a:
	assert property (read && !waitrequest && address[31:12] != 20'h5000_3 |-> readdata == 0)
		else $error("Unmapped read returned data");
	trio_off_a:
	assert property (!trio[0] && !$past(trio[0]) |-> trio_pwm_out == 3'h0)
		else $error("Trio outputs active while disabled");
	trio_hold_a:
	assert property (hold && $past(hold) && $past(hold, 2) |-> $stable(trio_pwm_out))
		else $error("Trio outputs moved while paused");
	timer_off_a:
	assert property (!tctl[0] && !$past(tctl[0]) |-> !timer_pwm_high && !timer_pwm_low)
		else $error("Timer outputs active while stopped");
	phase_excl_a:
	assert property (!(timer_pwm_high && timer_pwm_low)) else $error("Both phases active");
	high_low_a:
	assert property (tctl[0] && $past(tctl[0]) && !tctl[3] && !$past(tctl[3])
		&& $fell(timer_pwm_high) |-> timer_pwm_low) else $error("High phase not followed by low");
	freeze_hold_a:
	assert property (frz && $past(frz) && $past(frz, 2) && tctl[0] && $past(tctl[0])
		|-> $stable({timer_pwm_high, timer_pwm_low})) else $error("Timer moved while frozen");
endmodule

bind timer_pwm_top timer_pwm_top_asserts i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.hw_hold_req(hw_hold_req), .timer_pwm_high(timer_pwm_high),
	.timer_pwm_low(timer_pwm_low), .trio_pwm_out(trio_pwm_out));

/* File: testbench/tb.sv */
// Self-checking bench for the timer and trio PWM top over Avalon-MM.
// Assumes one wait state per access and a raised slow rate to keep runs short.
`timescale 1ns/100ps
`include "timer_pwm_regs.svh"
module tb;
	localparam int SLOW = 25000000;   // Slow tick every ten cycles
	logic        ref_clk, sys_rst, read, write, waitrequest, hw_hold_req;
	logic        timer_pwm_high, timer_pwm_low;
	logic [31:0] address, writedata, readdata, q, q0;
	logic [3:0]  byteenable;
	logic [2:0]  trio_pwm_out;
	int          errors, checked, rises, highs, hi[3];
	logic [31:0] ra[10] = '{`TP_IDX_TIMER_CTRL, `TP_IDX_ON_RELOAD, `TP_IDX_HIGH_RELOAD,
		`TP_IDX_LOW_RELOAD, `TP_IDX_DUTY_A, `TP_IDX_DUTY_B, `TP_IDX_DUTY_C,
		`TP_IDX_PERIOD, `TP_IDX_TRIO_CTRL, 32'h0000_0010};   // Last one is unmapped

	timer_pwm_top #(.SLOW_HZ(SLOW)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.hw_hold_req(hw_hold_req), .timer_pwm_high(timer_pwm_high),
		.timer_pwm_low(timer_pwm_low), .trio_pwm_out(trio_pwm_out));

	// 250 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Verdict and the single exit of the run
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Rate figures carry one cycle of tick jitter, so allow a margin
	task automatic near(input string nm, input int e, input int g, input int t);
		chk(nm, e, (g > e - t && g < e + t) ? e : g);
	endtask

	// One bus access; held until waitrequest is seen low at an edge
	task automatic acc(input logic wr, input logic [31:0] a, input logic [15:0] d);
		int n;
		@(posedge ref_clk);
		address   <= a;
		writedata <= {16'h0000, d};
		write     <= wr;
		read      <= !wr;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		if (n >= 20)
		begin
			chk("bus answer", 0, 1);
			end_sim();
		end
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
		acc(1'b0, a, 16'h0000);
		chk(nm, e, q);
	endtask

	// Count phase rises, high cycles and trio highs over n cycles
	task automatic meas(input int n);
		logic prev;
		prev  = timer_pwm_high;
		rises = 0;
		highs = 0;
		hi    = '{0, 0, 0};
		repeat (n)
		begin
			@(posedge ref_clk);
			rises += int'(timer_pwm_high && !prev);
			prev = timer_pwm_high;
			highs += int'(timer_pwm_high);
			foreach (hi[k]) hi[k] += int'(trio_pwm_out[k]);
		end
	endtask

	// Timer run: high phase 4 ticks, low phase 6, so ten ticks a period
	task automatic tm(input logic [15:0] c, input int t, input int dv, input int hf);
		acc(1'b1, `TP_IDX_TIMER_CTRL, c);
		repeat (400) @(posedge ref_clk);
		acc(1'b0, `TP_IDX_ON_RELOAD, 16'h0000);
		q0 = q;
		meas(3000);
		acc(1'b0, `TP_IDX_ON_RELOAD, 16'h0000);
		near("on count rate", t / dv, int'(q0[15:0] - q[15:0]), 5);
		near("phase rises", t / 10 * hf, rises, 3);
		near("high cycles", 1200 / hf, highs, 90);
	endtask

	initial
	begin
		sys_rst = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 32'h0000_0000;
		writedata = 32'h0000_0000;
		byteenable = 4'h3;
		hw_hold_req = 1'b0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (ra[i]) rd(ra[i], (i == 8) ? 32'h0000_0004 : 32'h0000_0000, "reset value");
		$display("Test reset values done");
		acc(1'b1, `TP_IDX_DUTY_A, 16'hFFFF);
		rd(`TP_IDX_DUTY_A, 32'h0000_3FFF, "duty width");
		acc(1'b1, `TP_IDX_DUTY_A, 16'h0003);
		acc(1'b1, `TP_IDX_DUTY_B, 16'h000A);
		acc(1'b1, `TP_IDX_PERIOD, 16'h000A);
		rd(`TP_IDX_PERIOD, 32'h0000_000A, "period");
		acc(1'b1, 32'h0000_0010, 16'hFFFF);
		rd(32'h0000_0010, 32'h0000_0000, "unmapped");
		$display("Test registers done");
		acc(1'b1, `TP_IDX_TRIO_CTRL, 16'h0005);
		repeat (5) @(posedge ref_clk);
		meas(10);
		chk("duty a", 3, hi[0]);
		chk("duty b", 10, hi[1]);
		chk("duty c", 0, hi[2]);
		acc(1'b1, `TP_IDX_TRIO_CTRL, 16'h0007);
		repeat (4) @(posedge ref_clk);
		meas(10);
		chk("sw hold", 0, hi[0] % 10);
		acc(1'b1, `TP_IDX_TRIO_CTRL, 16'h0005);
		hw_hold_req <= 1'b1;
		repeat (4) @(posedge ref_clk);
		meas(10);
		chk("hw hold", 0, hi[0] % 10);
		acc(1'b1, `TP_IDX_TRIO_CTRL, 16'h0001);
		repeat (4) @(posedge ref_clk);
		meas(10);
		chk("hw hold barred", 3, hi[0]);
		hw_hold_req <= 1'b0;
		acc(1'b1, `TP_IDX_TRIO_CTRL, 16'h0000);
		repeat (3) @(posedge ref_clk);
		meas(10);
		chk("trio off", 0, hi[0] + hi[1] + hi[2]);
		$display("Test trio PWM done");
		acc(1'b1, `TP_IDX_ON_RELOAD, 16'h4000);
		acc(1'b1, `TP_IDX_HIGH_RELOAD, 16'h0003);
		acc(1'b1, `TP_IDX_LOW_RELOAD, 16'h0005);
		rd(`TP_IDX_ON_RELOAD, 32'h0000_0000, "on count idle");
		rd(`TP_IDX_HIGH_RELOAD, 32'h0000_0000, "phase idle");
		rd(`TP_IDX_LOW_RELOAD, 32'h0000_0000, "phase idle");
		tm(16'h0003, 192, 10, 1);
		tm(16'h0005, 3000 / (250000000 / SLOW), 1, 1);
		tm(16'h000F, 192, 1, 2);
		acc(1'b1, `TP_IDX_FAST_SEL, 16'h0001);
		rd(`TP_IDX_FAST_SEL, 32'h0000_0001, "fast rate select");
		tm(16'h000F, 96, 1, 2);
		$display("Test timer rates done");
		acc(1'b1, `TP_IDX_FREEZE_SET, 16'h0002);
		acc(1'b0, `TP_IDX_ON_RELOAD, 16'h0000);
		q0 = q;
		repeat (200) @(posedge ref_clk);
		rd(`TP_IDX_ON_RELOAD, q0, "frozen count");
		acc(1'b1, `TP_IDX_FREEZE_SET, 16'h0000);
		repeat (200) @(posedge ref_clk);
		rd(`TP_IDX_ON_RELOAD, q0, "zero write ignored");
		rd(`TP_IDX_FREEZE_SET, 32'h0000_0002, "freeze state");
		acc(1'b1, `TP_IDX_FREEZE_CLR, 16'h0002);
		repeat (200) @(posedge ref_clk);
		acc(1'b0, `TP_IDX_ON_RELOAD, 16'h0000);
		chk("released", 1, q !== q0);
		acc(1'b1, `TP_IDX_TIMER_CTRL, 16'h0000);
		repeat (3) @(posedge ref_clk);
		chk("stopped outputs", 0, {timer_pwm_high, timer_pwm_low});
		rd(`TP_IDX_ON_RELOAD, 32'h0000_0000, "stopped count");
		$display("Test freeze and stop done");
		end_sim();
	end
endmodule
